/* File: src/etc_pkg.sv */
package etc_pkg;
  localparam logic [7:0] ETC_COUNT_RST    = 8'h00;
  localparam logic [7:0] ETC_COUNT_MAX    = 8'hff;
  localparam logic [7:0] ETC_PRE_RST      = 8'h00;
  localparam logic [1:0] ETC_HOLD_CYCLES  = 2'h2;
  localparam logic [1:0] ETC_GSS_OVERFLOW = 2'h1;

  typedef struct packed {
    logic       count_source_select;
    logic       count_edge_select;
    logic       prescaler_bypass;
    logic [2:0] prescale_rate;
  } etc_cfg_t;
endpackage

/* File: src/etc_timer.sv */
`timescale 1ns/1ns
module etc_timer
  import etc_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire etc_pkg::etc_cfg_t cfg_in,
  input  wire logic              wr_en_in,
  input  wire logic [7:0]        wr_data_in,
  input  wire logic              flag_clr_in,
  input  wire logic              external_count_clock_pin_in,
  input  wire logic [1:0]        companion_gate_source_select_in,
  output logic [7:0]             count_register_out,
  output logic                   overflow_flag_out,
  output logic                   overflow_gate_output_out,
  output logic                   companion_gate_out
);
  import etc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: stage one feeds only stage two.
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       pin_lvl_q;
  logic       pin_lvl_d;

  always_comb
  begin
    sync_d    = {sync_q[1:0], external_count_clock_pin_in};
    pin_lvl_d = pin_lvl_q;
    if (sync_q[1] == sync_q[2])
    begin
      pin_lvl_d = sync_q[2];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sync_q    <= 3'h0;
      pin_lvl_q <= 1'b0;
    end
    else
    begin
      sync_q    <= sync_d;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection and edge qualification.
  logic src_lvl;
  logic src_prev_q;
  logic src_prev_d;
  logic tick;
  logic icyc_q;
  logic icyc_d;

  always_comb
  begin
    icyc_d     = ~icyc_q;
    // The internal source is a toggle so that one edge kind occurs per cycle pair; both edges count in timer mode.
    src_lvl    = cfg_in.count_source_select ? pin_lvl_q : icyc_q;
    src_prev_d = src_lvl;
    if (!cfg_in.count_source_select)
    begin
      tick = 1'b1;
    end
    else if (cfg_in.count_edge_select)
    begin
      tick = src_prev_q & ~src_lvl;
    end
    else
    begin
      tick = ~src_prev_q & src_lvl;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      src_prev_q <= 1'b0;
      icyc_q     <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_prev_d;
      icyc_q     <= icyc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler, count register, write hold-off and overflow.
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic       inc;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  logic [7:0] cnt_d;
  logic       flag_d;
  logic       ovf_d;
  logic       ovf;
  logic       gate_d;

  always_comb
  begin
    pre_d  = pre_q;
    inc    = 1'b0;
    hold_d = hold_q;
    cnt_d  = count_register_out;
    flag_d = overflow_flag_out;
    ovf    = 1'b0;
    if (tick)
    begin
      if (cfg_in.prescaler_bypass)
      begin
        inc = 1'b1;
      end
      else
      begin
        // Divide by 2^(rate+1): 1:2 up to 1:256.
        pre_d = pre_q + 8'h01;
        inc   = (pre_d & ((8'h02 << cfg_in.prescale_rate) - 8'h01)) == 8'h00;
      end
    end
    if (wr_en_in)
    begin
      cnt_d  = wr_data_in;
      hold_d = ETC_HOLD_CYCLES;
      pre_d  = ETC_PRE_RST;
    end
    else if (hold_q != 2'h0)
    begin
      hold_d = hold_q - 2'h1;
    end
    else if (inc)
    begin
      cnt_d = count_register_out + 8'h01;
      ovf   = count_register_out == ETC_COUNT_MAX;
    end
    ovf_d = ovf;
    gate_d = (companion_gate_source_select_in == ETC_GSS_OVERFLOW) & ovf;
    if (flag_clr_in)
    begin
      flag_d = 1'b0;
    end
    if (ovf)
    begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pre_q                    <= ETC_PRE_RST;
      hold_q                   <= 2'h0;
      count_register_out       <= ETC_COUNT_RST;
      overflow_flag_out        <= 1'b0;
      overflow_gate_output_out <= 1'b0;
      companion_gate_out       <= 1'b0;
    end
    else
    begin
      pre_q                    <= pre_d;
      hold_q                   <= hold_d;
      count_register_out       <= cnt_d;
      overflow_flag_out        <= flag_d;
      overflow_gate_output_out <= ovf_d;
      companion_gate_out       <= gate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in ##1 !wr_en_in [*2] |-> $stable(count_register_out))
    else $error("count moved during write hold-off");

  AST_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in |=> count_register_out == $past(wr_data_in))
    else $error("write not loaded");

  AST_TIMER: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!wr_en_in && hold_q == 2'h0 && !cfg_in.count_source_select && cfg_in.prescaler_bypass)
    |=> count_register_out == $past(count_register_out) + 8'h01)
    else $error("timer mode did not advance");

  AST_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
    (overflow_flag_out && !flag_clr_in) |=> overflow_flag_out)
    else $error("flag dropped without clear");

  AST_ROLL: assert property (@(posedge mclk_in) disable iff (rst_in)
    ($past(count_register_out) == 8'hff && count_register_out == 8'h00 && !$past(wr_en_in)) |-> overflow_flag_out)
    else $error("rollover without flag");

  AST_GATE: assert property (@(posedge mclk_in) disable iff (rst_in)
    companion_gate_out |-> overflow_gate_output_out && $past(companion_gate_source_select_in) == 2'h1)
    else $error("gate without select 01");

  AST_PIN: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cfg_in.count_source_select && $stable(src_lvl) && !wr_en_in) |=> $stable(count_register_out))
    else $error("counter mode moved without edge");

  AST_PRE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!cfg_in.prescaler_bypass && !cfg_in.count_source_select && cfg_in.prescale_rate == 3'h0 && !wr_en_in
     && hold_q == 2'h0 && pre_q[0]) |=> count_register_out == $past(count_register_out) + 8'h01)
    else $error("prescaler 1:2 missed");

  ////////////////////////////////////////////////////////////////////////////////
  // Further checks on hold-off, overflow, gate routing and edge qualification.
  AST_HOLD2: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in ##1 !wr_en_in [*2]
    |=> $stable(count_register_out))
    else $error("count moved in second hold-off cycle");

  AST_RESUME: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in ##1 (!wr_en_in && !cfg_in.count_source_select && cfg_in.prescaler_bypass) [*3]
    |=> count_register_out == $past(count_register_out) + 8'h01)
    else $error("count did not resume after hold-off");

  AST_HOLD_LOAD: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in
    |=> hold_q == ETC_HOLD_CYCLES)
    else $error("hold-off not started by write");

  AST_HOLD_DEC: assert property (@(posedge mclk_in) disable iff (rst_in)
    (hold_q != 2'h0 && !wr_en_in)
    |=> hold_q == $past(hold_q) - 2'h1)
    else $error("hold-off did not count down");

  AST_WR_NOOVF: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in
    |=> !overflow_gate_output_out)
    else $error("overflow reported on a write");

  AST_OVF_PULSE: assert property (@(posedge mclk_in) disable iff (rst_in)
    overflow_gate_output_out
    |=> !overflow_gate_output_out)
    else $error("overflow pulse longer than one cycle");

  AST_OVF_CNT: assert property (@(posedge mclk_in) disable iff (rst_in)
    overflow_gate_output_out
    |-> count_register_out == ETC_COUNT_RST && $past(count_register_out) == ETC_COUNT_MAX)
    else $error("overflow pulse without rollover");

  AST_OVF_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
    overflow_gate_output_out
    |-> overflow_flag_out)
    else $error("overflow pulse without flag");

  AST_ROSE_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(overflow_flag_out)
    |-> overflow_gate_output_out)
    else $error("flag set without overflow");

  AST_CLR: assert property (@(posedge mclk_in) disable iff (rst_in)
    flag_clr_in ##1 !overflow_gate_output_out
    |-> !overflow_flag_out)
    else $error("flag not cleared");

  AST_GATE_SEL: assert property (@(posedge mclk_in) disable iff (rst_in)
    (overflow_gate_output_out && $past(companion_gate_source_select_in) == ETC_GSS_OVERFLOW)
    |-> companion_gate_out)
    else $error("selected gate missed overflow");

  AST_GATE_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    ($past(companion_gate_source_select_in) != ETC_GSS_OVERFLOW)
    |-> !companion_gate_out)
    else $error("gate driven while not selected");

  AST_IDLE_GATE: assert property (@(posedge mclk_in) disable iff (rst_in)
    !overflow_gate_output_out
    |-> !companion_gate_out)
    else $error("gate without overflow");

  AST_SYNC: assert property (@(posedge mclk_in) disable iff (rst_in)
    !$stable(pin_lvl_q)
    |-> $past(sync_q[1]) == $past(sync_q[2]))
    else $error("pin level taken before stages agreed");

  AST_RISE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cfg_in.count_source_select && !cfg_in.count_edge_select && cfg_in.prescaler_bypass && !wr_en_in
     && hold_q == 2'h0 && !src_prev_q && src_lvl)
    |=> count_register_out == $past(count_register_out) + 8'h01)
    else $error("rising pin edge not counted");

  AST_FALL: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cfg_in.count_source_select && cfg_in.count_edge_select && cfg_in.prescaler_bypass && !wr_en_in
     && hold_q == 2'h0 && src_prev_q && !src_lvl)
    |=> count_register_out == $past(count_register_out) + 8'h01)
    else $error("falling pin edge not counted");

  AST_NOEDGE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cfg_in.count_source_select && !cfg_in.count_edge_select && src_prev_q && !src_lvl && !wr_en_in)
    |=> $stable(count_register_out))
    else $error("unselected edge counted");

  AST_PRE_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!cfg_in.prescaler_bypass && !cfg_in.count_source_select && cfg_in.prescale_rate == 3'h0 && !wr_en_in
     && !pre_q[0])
    |=> $stable(count_register_out))
    else $error("prescaler 1:2 counted early");

  AST_PRE_RESTART: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_en_in
    |=> pre_q == ETC_PRE_RST)
    else $error("prescaler not restarted by write");

  AST_CNT_STEP: assert property (@(posedge mclk_in) disable iff (rst_in)
    !wr_en_in
    |=> count_register_out == $past(count_register_out) || count_register_out == $past(count_register_out) + 8'h01)
    else $error("count jumped by more than one");

  AST_RST: assert property (@(posedge mclk_in)
    $fell(rst_in)
    |-> count_register_out == ETC_COUNT_RST && !overflow_flag_out && !companion_gate_out)
    else $error("state not cleared by reset");
endmodule

/* File: tb/etc_pin_model.sv */
`timescale 1ns/1ns
module etc_pin_model
(
  input  wire logic       mclk_in,
  input  wire logic       start_in,
  input  wire logic [3:0] pulses_in,
  output logic            pin_out,
  output logic            done_out
);
  logic [7:0] left_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Each pulse is 8 cycles high and 8 low, long enough for the input filter.
  always_ff @(posedge mclk_in)
  begin
    if (start_in)
    begin
      left_q <= {pulses_in, 4'h0};
    end
    else if (left_q != 8'h00)
    begin
      left_q <= left_q - 8'h01;
    end
  end
  // The pin rests low outside a burst, so no stray edge is offered.
  assign pin_out  = (left_q != 8'h00) && left_q[3];
  assign done_out = (left_q == 8'h00);
endmodule

/* File: tb/etc_timer_tb.sv */
`timescale 1ns/1ns
module etc_timer_tb;
  import etc_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_in, wr_en, clr, start, pin, ovf, cg, flag, done;
  etc_cfg_t   cfg;
  logic [7:0] wr_data, cnt;
  logic [1:0] gss;
  logic [3:0] pulses;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  always #50 mclk_in = ~mclk_in;
  etc_timer etc_timer_i (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_in(cfg), .wr_en_in(wr_en),
    .wr_data_in(wr_data), .flag_clr_in(clr), .external_count_clock_pin_in(pin),
    .companion_gate_source_select_in(gss), .count_register_out(cnt), .overflow_flag_out(flag),
    .overflow_gate_output_out(ovf), .companion_gate_out(cg));
  etc_pin_model etc_pin_model_i (.mclk_in(mclk_in), .start_in(start), .pulses_in(pulses),
    .pin_out(pin), .done_out(done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #10;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    wr_en = 1'b1;
    wr_data = v;
    tick(1);
    wr_en = 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_hold;
    cfg = '{1'b0, 1'b0, 1'b1, 3'h0};
    wr(8'h10);
    chk("count", 8'h10, cnt);
    tick(2);
    chk("count", 8'h10, cnt);
    tick(1);
    chk("count", 8'h11, cnt);
    tick(5);
    chk("count", 8'h16, cnt);
  endtask
  task automatic t_ovf(input logic [1:0] sel);
    logic [7:0] g;
    logic [7:0] c;
    g = 8'h00;
    c = 8'h00;
    gss = sel;
    wr(8'hfe);
    tick(3);
    chk("count", 8'hff, cnt);
    repeat (4)
    begin
      tick(1);
      g = g + {7'h0, ovf};
      c = c + {7'h0, cg};
    end
    chk("gate pulses", 8'h01, g);
    chk("companion pulses", {7'h0, sel == 2'h1}, c);
    chk("flag", 8'h01, {7'h0, flag});
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    chk("flag", 8'h00, {7'h0, flag});
  endtask
  task automatic t_pre(input logic [2:0] rate, input logic [7:0] exp);
    cfg = '{1'b0, 1'b0, 1'b0, rate};
    wr(8'h00);
    tick(41);
    chk("prescaled", exp, cnt);
  endtask
  task automatic t_pin(input logic fall);
    cfg = '{1'b1, fall, 1'b1, 3'h0};
    wr(8'h00);
    tick(3);
    pulses = 4'h3;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(7);
    chk("first edge", {7'h0, !fall}, cnt);
    tick(50);
    chk("pin count", 8'h03, cnt);
    chk("pin done", 8'h01, {7'h0, done});
  endtask
  initial
  begin
    rst_in = 1'b1;
    cfg = '{1'b0, 1'b0, 1'b1, 3'h0};
    {wr_en, clr, gss, wr_data} = '0;
    start = 1'b1;
    pulses = 4'h0;
    tick(2);
    rst_in = 1'b0;
    start = 1'b0;
    chk("reset count", 8'h00, cnt);
    t_hold();
    t_ovf(2'h1);
    t_ovf(2'h2);
    t_pre(3'h0, 8'd19);
    t_pre(3'h2, 8'd5);
    t_pin(1'b0);
    t_pin(1'b1);
    end_sim();
  end
endmodule
